// >>> rtl/rctm_pkg.sv
`default_nettype none
package rctm_pkg;
  // avalon byte address, one 32-bit word per register
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 8;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_HD_ADMIT = 8'h82;
  localparam logic [IDX_W-1:0] IDX_LN_CLEAR = 8'h83;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'h84;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h85;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h86;
  // field positions and byte lanes
  localparam int unsigned HD_ACCEPT_BIT = 7;
  localparam int unsigned HD_ACCEPT_LANE = 0;
  localparam int unsigned LN_CLEAR_BIT = 15;
  localparam int unsigned LN_CLEAR_LANE = 1;
  localparam int unsigned EV_LANE = 0;
  // reset values
  localparam logic HD_ACCEPT_RST = 1'b0;
  localparam logic LN_CLEAR_RST = 1'b0;
  // interrupt event bits (status and mask share the layout)
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_REF_LOST = 0;
  localparam int unsigned EV_REF_FOUND = 1;
  localparam int unsigned EV_LN_CLEAR = 2;
  localparam int unsigned EV_TEST_MODE = 3;
  localparam logic [EV_W-1:0] EV_NONE = 4'h0;
  // read-only state word
  localparam int unsigned ST_REF_LOST = 0;
  localparam int unsigned ST_REF_OK = 1;
  localparam int unsigned ST_TEST_MODE = 2;
  // host port pins and their test-mode functions
  localparam int unsigned HOST_PIN_W = 4;
  localparam int unsigned PIN_TCK = 0;
  localparam int unsigned PIN_TDI = 1;
  localparam int unsigned PIN_TDO = 2;
  localparam int unsigned PIN_TMS = 3;
  localparam logic [HOST_PIN_W-1:0] TDO_OE_MASK = 4'h4;
  // bus answer states
  typedef enum logic [1:0] {
    RCTM_BUS_IDLE = 2'b01,
    RCTM_BUS_ANSWER = 2'b10
  } rctm_bus_state_t;

  // word index from a byte address
  function automatic logic [IDX_W-1:0] rctm_word_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction
endpackage
`default_nettype wire

// >>> rtl/rctm_sync_if.sv
`default_nettype none
interface rctm_sync_if;
  logic raw;
  logic stable;
  modport sync_side(input raw, output stable);
  modport user_side(output raw, input stable);
endinterface
`default_nettype wire

// >>> rtl/rctm_sync.sv
`default_nettype none
module rctm_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // pin in, filtered level out
  rctm_sync_if.sync_side sif
);
  logic ff1_r, ff2_r, ff3_r, stable_r;
  logic stable_nxt;

  // a change counts only once the second and third stages agree
  always_comb begin
    stable_nxt = (ff2_r == ff3_r) ? ff3_r : stable_r;
  end

  // first stage feeds only the second: no logic reads a metastable value
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
      stable_r <= RST_VAL;
    end else begin
      ff1_r <= sif.raw;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      stable_r <= stable_nxt;
    end
  end

  assign sif.stable = stable_r;
endmodule
`default_nettype wire

// >>> rtl/rctm_top.sv
// Added by the designer: register access over Avalon-MM.
`default_nettype none
module rctm_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [rctm_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [rctm_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [rctm_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // reference detector, same clock
  input wire logic ref_present_i,
  input wire logic ref_format_known_i,
  input wire logic ref_is_hd_i,
  input wire logic ref_hd_enabled_i,
  output logic ref_recognised_o,
  output logic ref_lost_o,
  // line counter clear towards the timing generator
  output logic line_counter_reset_o,
  // device pins
  input wire logic test_select_i,
  input wire logic reset_pin_n_i,
  input wire logic [rctm_pkg::HOST_PIN_W-1:0] host_pin_i,
  output logic [rctm_pkg::HOST_PIN_W-1:0] host_pin_o,
  output logic [rctm_pkg::HOST_PIN_W-1:0] host_pin_oe_o,
  // host interface logic behind the pins
  input wire logic [rctm_pkg::HOST_PIN_W-1:0] host_out_i,
  input wire logic [rctm_pkg::HOST_PIN_W-1:0] host_oe_i,
  output logic [rctm_pkg::HOST_PIN_W-1:0] host_in_o,
  // boundary-scan tap
  input wire logic tap_tdo_i,
  output logic tap_enable_o,
  output logic test_clock_pin_o,
  output logic tap_tdi_o,
  output logic tap_tms_o,
  output logic tap_trst_n_o
);
  rctm_sync_if sel_if ();
  rctm_sync_if rpin_if ();
  logic test_mode, rpin_n, soft_rst;
  logic wr_go, rd_take;
  logic [rctm_pkg::IDX_W-1:0] idx;
  rctm_pkg::rctm_bus_state_t state_r, state_nxt;
  logic [rctm_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic hd_accept_r, hd_accept_nxt;
  logic ln_bit_r, ln_bit_nxt, ln_prev_r, ln_prev_nxt, ln_pulse_r, ln_pulse_nxt;
  logic ref_ok_r, ref_ok_nxt, ref_lost_r, ref_lost_nxt, test_d_r, test_d_nxt;
  logic [rctm_pkg::EV_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev, w1c;

  // test select and reset pins are filtered before use
  assign sel_if.raw = test_select_i;
  assign rpin_if.raw = reset_pin_n_i;

  rctm_sync #(.RST_VAL(1'b0)) u_sel_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sif(sel_if.sync_side)
  );

  rctm_sync #(.RST_VAL(1'b1)) u_rpin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sif(rpin_if.sync_side)
  );

  assign test_mode = sel_if.stable;
  assign rpin_n = rpin_if.stable;
  // pin reset defaults
  // in test mode the pin belongs to the tap, so it must not wipe registers
  assign soft_rst = !test_mode && !rpin_n;

  // bus handshake: one wait state, write lands when waitrequest is low
  assign idx = rctm_pkg::rctm_word_index(avs_address_i);
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (state_r != rctm_pkg::RCTM_BUS_ANSWER);
  assign wr_go = avs_write_i && (state_r == rctm_pkg::RCTM_BUS_ANSWER);
  assign rd_take = avs_read_i && (state_r == rctm_pkg::RCTM_BUS_IDLE);
  assign avs_readdata_o = rdata_r;

  // bus state and read data next values
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    case (state_r)
      rctm_pkg::RCTM_BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          state_nxt = rctm_pkg::RCTM_BUS_ANSWER;
        end
        if (rd_take) begin
          rdata_nxt = '0;
          case (idx)
            rctm_pkg::IDX_HD_ADMIT: rdata_nxt[rctm_pkg::HD_ACCEPT_BIT] = hd_accept_r;
            rctm_pkg::IDX_LN_CLEAR: rdata_nxt[rctm_pkg::LN_CLEAR_BIT] = ln_bit_r;
            rctm_pkg::IDX_IRQ_STAT: rdata_nxt[rctm_pkg::EV_W-1:0] = stat_r;
            rctm_pkg::IDX_IRQ_MASK: rdata_nxt[rctm_pkg::EV_W-1:0] = mask_r;
            rctm_pkg::IDX_STATUS: begin
              rdata_nxt[rctm_pkg::ST_REF_LOST] = ref_lost_r;
              rdata_nxt[rctm_pkg::ST_REF_OK] = ref_ok_r;
              rdata_nxt[rctm_pkg::ST_TEST_MODE] = test_mode;
            end
            default: rdata_nxt = '0; // unmapped reads zero
          endcase
        end
      end
      rctm_pkg::RCTM_BUS_ANSWER: state_nxt = rctm_pkg::RCTM_BUS_IDLE;
      default: state_nxt = rctm_pkg::RCTM_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= rctm_pkg::RCTM_BUS_IDLE;
      rdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // control registers; reserved bits are simply not stored
  always_comb begin
    hd_accept_nxt = hd_accept_r;
    ln_bit_nxt = ln_bit_r;
    mask_nxt = mask_r;
    w1c = rctm_pkg::EV_NONE;
    if (wr_go && idx == rctm_pkg::IDX_HD_ADMIT && avs_byteenable_i[rctm_pkg::HD_ACCEPT_LANE]) begin
      hd_accept_nxt = avs_writedata_i[rctm_pkg::HD_ACCEPT_BIT];
    end
    if (wr_go && idx == rctm_pkg::IDX_LN_CLEAR && avs_byteenable_i[rctm_pkg::LN_CLEAR_LANE]) begin
      ln_bit_nxt = avs_writedata_i[rctm_pkg::LN_CLEAR_BIT];
    end
    if (wr_go && idx == rctm_pkg::IDX_IRQ_MASK && avs_byteenable_i[rctm_pkg::EV_LANE]) begin
      mask_nxt = avs_writedata_i[rctm_pkg::EV_W-1:0];
    end
    if (wr_go && idx == rctm_pkg::IDX_IRQ_STAT && avs_byteenable_i[rctm_pkg::EV_LANE]) begin
      w1c = avs_writedata_i[rctm_pkg::EV_W-1:0];
    end
    if (soft_rst) begin
      hd_accept_nxt = rctm_pkg::HD_ACCEPT_RST;
      ln_bit_nxt = rctm_pkg::LN_CLEAR_RST;
      mask_nxt = rctm_pkg::EV_NONE;
      w1c = '1;
    end
  end

  // reference qualification and counter clear pulse
  always_comb begin
    ref_ok_nxt = ref_present_i && ref_format_known_i &&
                 (!ref_is_hd_i || (hd_accept_r && ref_hd_enabled_i));
    ref_lost_nxt = hd_accept_r ? !ref_present_i : !ref_ok_nxt;
    ln_pulse_nxt = ln_bit_r ^ ln_prev_r;
    ln_prev_nxt = ln_bit_r;
    test_d_nxt = test_mode;
  end

  // interrupt status: an event in the clearing cycle survives
  always_comb begin
    ev = rctm_pkg::EV_NONE;
    ev[rctm_pkg::EV_REF_LOST] = ref_lost_nxt && !ref_lost_r;
    ev[rctm_pkg::EV_REF_FOUND] = ref_ok_nxt && !ref_ok_r;
    ev[rctm_pkg::EV_LN_CLEAR] = ln_pulse_nxt;
    ev[rctm_pkg::EV_TEST_MODE] = test_mode != test_d_r;
    stat_nxt = (stat_r & ~w1c) | ev;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hd_accept_r <= rctm_pkg::HD_ACCEPT_RST;
      ln_bit_r <= rctm_pkg::LN_CLEAR_RST;
      ln_prev_r <= rctm_pkg::LN_CLEAR_RST;
      ln_pulse_r <= 1'b0;
      ref_ok_r <= 1'b0;
      ref_lost_r <= 1'b1;
      test_d_r <= 1'b0;
      mask_r <= rctm_pkg::EV_NONE;
      stat_r <= rctm_pkg::EV_NONE;
    end else begin
      hd_accept_r <= hd_accept_nxt;
      ln_bit_r <= ln_bit_nxt;
      ln_prev_r <= ln_prev_nxt;
      ln_pulse_r <= ln_pulse_nxt;
      ref_ok_r <= ref_ok_nxt;
      ref_lost_r <= ref_lost_nxt;
      test_d_r <= test_d_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign ref_recognised_o = ref_ok_r;
  assign ref_lost_o = ref_lost_r;
  assign line_counter_reset_o = ln_pulse_r;
  assign irq_o = |(stat_r & mask_r);

  // pin mux: combinational only, the tap samples on its own clock
  always_comb begin
    host_pin_o = host_out_i;
    host_pin_oe_o = host_oe_i;
    host_in_o = host_pin_i;
    if (test_mode) begin
      host_pin_o = '0;
      host_pin_o[rctm_pkg::PIN_TDO] = tap_tdo_i;
      host_pin_oe_o = rctm_pkg::TDO_OE_MASK;
      host_in_o = '0;
    end
  end

  assign tap_enable_o = test_mode;
  assign test_clock_pin_o = test_mode && host_pin_i[rctm_pkg::PIN_TCK];
  assign tap_tdi_o = test_mode && host_pin_i[rctm_pkg::PIN_TDI];
  assign tap_tms_o = test_mode && host_pin_i[rctm_pkg::PIN_TMS];
  assign tap_trst_n_o = test_mode && rpin_n;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_hd_refused: assert property (
    (ref_present_i && ref_is_hd_i && !hd_accept_r) |=> !ref_recognised_o
  ) else $error("hd reference recognised while not admitted");
  chk_lost_removal_only: assert property (
    (hd_accept_r && ref_present_i) |=> !ref_lost_o
  ) else $error("reference lost raised without removal");
  chk_lost_on_removal: assert property (
    !ref_present_i |=> ref_lost_o
  ) else $error("reference removal not flagged");
  chk_clear_toggle_pulse: assert property (
    $changed(ln_bit_r) |=> line_counter_reset_o ##1 !line_counter_reset_o
  ) else $error("toggle did not give one counter reset");
  chk_clear_no_spurious: assert property (
    (ln_bit_r == ln_prev_r) |=> !line_counter_reset_o
  ) else $error("counter reset without toggle");
  chk_test_select_entry: assert property (
    test_select_i [*4] |=> tap_enable_o
  ) else $error("test select did not enter test mode");
  chk_test_pin_drive: assert property (
    tap_enable_o |-> (host_pin_oe_o == rctm_pkg::TDO_OE_MASK && host_in_o == '0)
  ) else $error("test mode pin directions wrong");
  chk_trst_follow: assert property (
    tap_enable_o |-> (tap_trst_n_o == rpin_n)
  ) else $error("test reset does not follow reset pin");
  chk_tap_idle_host: assert property (
    !tap_enable_o |-> (!tap_trst_n_o && !test_clock_pin_o && host_pin_oe_o == host_oe_i)
  ) else $error("scan port active outside test mode");
  chk_pin_reset_defaults: assert property (
    soft_rst |=> (!hd_accept_r && !ln_bit_r && mask_r == rctm_pkg::EV_NONE && !irq_o)
  ) else $error("reset pin left registers set");
  chk_bus_answer: assert property (
    ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o
  ) else $error("bus answer later than one wait state");
  // status bits stay set until a one is written to them or the reset pin clears them
  chk_stat_sticky: assert property (
    (w1c == rctm_pkg::EV_NONE) |=> ((stat_r & $past(stat_r)) == $past(stat_r))
  ) else $error("status bit lost without a clear");
  chk_stat_set_wins: assert property (
    (ev != rctm_pkg::EV_NONE) |=> ((stat_r & $past(ev)) == $past(ev))
  ) else $error("event lost against a clear");
  chk_admit_write: assert property (
    (wr_go && idx == rctm_pkg::IDX_HD_ADMIT && avs_byteenable_i[rctm_pkg::HD_ACCEPT_LANE] &&
     !soft_rst) |=> (hd_accept_r == $past(avs_writedata_i[rctm_pkg::HD_ACCEPT_BIT]))
  ) else $error("admit bit write did not land");
  chk_hd_admitted_seen: assert property (
    (ref_present_i && ref_format_known_i && ref_is_hd_i && ref_hd_enabled_i && hd_accept_r)
      |=> ref_recognised_o
  ) else $error("admitted hd reference not recognised");
  chk_hd_mask_refused: assert property (
    (ref_is_hd_i && !ref_hd_enabled_i) |=> !ref_recognised_o
  ) else $error("hd reference recognised outside format mask");
  chk_clear_bit_write: assert property (
    (wr_go && idx == rctm_pkg::IDX_LN_CLEAR && avs_byteenable_i[rctm_pkg::LN_CLEAR_LANE] &&
     !soft_rst) |=> (ln_bit_r == $past(avs_writedata_i[rctm_pkg::LN_CLEAR_BIT]))
  ) else $error("clear bit write did not land");
  chk_tdo_to_pin: assert property (
    tap_enable_o |-> (host_pin_o[rctm_pkg::PIN_TDO] == tap_tdo_i)
  ) else $error("tap data out not on its pin");
  chk_tap_pin_follow: assert property (
    tap_enable_o |-> (tap_tms_o == host_pin_i[rctm_pkg::PIN_TMS] &&
                      tap_tdi_o == host_pin_i[rctm_pkg::PIN_TDI])
  ) else $error("tap inputs do not follow their pins");
endmodule
`default_nettype wire

// >>> verif/rctm_ate_model.sv
`default_nettype none
module rctm_ate_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // device side of the pins
  input wire logic scan_i,
  input wire logic [3:0] dev_pin_i,
  input wire logic [3:0] dev_oe_i,
  // resolved pin levels
  output logic [3:0] wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pat_r;
  logic [3:0] pat_nxt;
  // pattern moves every cycle so a stale level never passes for a live one
  always_comb begin
    pat_nxt = pat_r + 4'h1;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pat_r <= 4'h0;
    end else begin
      pat_r <= pat_nxt;
    end
  end
  // no double drive
  // far side lets go of every pin the device drives; test clock idles outside scan
  always_comb begin
    wire_o = pat_r;
    if (!scan_i) begin
      wire_o[0] = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      if (dev_oe_i[i]) begin
        wire_o[i] = dev_pin_i[i];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, irq_o, ref_recognised_o, ref_lost_o, line_counter_reset_o;
  logic ref_present_i = 1'b0;
  logic ref_format_known_i = 1'b0;
  logic ref_is_hd_i = 1'b0;
  logic ref_hd_enabled_i = 1'b0;
  logic test_select_i = 1'b0;
  logic reset_pin_n_i = 1'b1;
  logic tap_tdo_i = 1'b1;
  logic [3:0] host_out_i = 4'ha;
  logic [3:0] host_oe_i = 4'h2;
  logic [3:0] host_pin_i, host_pin_o, host_pin_oe_o, host_in_o;
  logic tap_enable_o, test_clock_pin_o, tap_tdi_o, tap_tms_o, tap_trst_n_o;
  int n_errors = 0;
  int total_checks = 0;
  int pulses = 0;
  int p0;
  int n;
  logic [31:0] q;
  rctm_top i_rctm_top (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o,
    .ref_present_i, .ref_format_known_i, .ref_is_hd_i, .ref_hd_enabled_i, .ref_recognised_o,
    .ref_lost_o, .line_counter_reset_o, .test_select_i, .reset_pin_n_i, .host_pin_i,
    .host_pin_o, .host_pin_oe_o, .host_out_i, .host_oe_i, .host_in_o, .tap_tdo_i, .tap_enable_o,
    .test_clock_pin_o, .tap_tdi_o, .tap_tms_o, .tap_trst_n_o);
  rctm_ate_model i_rctm_ate_model (.clk_sys_i, .rst_i, .scan_i(tap_enable_o),
    .dev_pin_i(host_pin_o), .dev_oe_i(host_pin_oe_o), .wire_o(host_pin_i));
  // clock
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // counts line counter clear pulses, one cycle each
  always @(posedge clk_sys_i) begin
    if (line_counter_reset_o === 1'b1) pulses++;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t word got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t bit got %b want %b", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic guard(input int cnt);
    if (cnt >= 40) begin
      n_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      results();
    end
  endtask
  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    k = 0;
    // waitrequest and read data taken at the rising edge that ends the wait
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 40);
    guard(k);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_word(q, exp);
  endtask
  // reference inputs settle one cycle after they change
  task automatic set_ref(input logic p, input logic k, input logic h, input logic e);
    @(posedge clk_sys_i);
    {ref_present_i, ref_format_known_i, ref_is_hd_i, ref_hd_enabled_i} <= {p, k, h, e};
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task automatic t_reset;
    rdchk(10'h208, 32'h0);
    rdchk(10'h20c, 32'h0);
    rdchk(10'h218, 32'h1);
    rdchk(10'h3fc, 32'h0);
    chk_bit(irq_o, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_hd;
    set_ref(1'b1, 1'b1, 1'b1, 1'b1);
    chk_bit(ref_recognised_o, 1'b0);
    bus(1'b1, 10'h208, 32'h80);
    rdchk(10'h208, 32'h80);
    avs_byteenable_i <= 4'he;
    bus(1'b1, 10'h208, 32'h0);
    avs_byteenable_i <= 4'hf;
    rdchk(10'h208, 32'h80);
    set_ref(1'b1, 1'b1, 1'b1, 1'b1);
    chk_bit(ref_recognised_o, 1'b1);
    set_ref(1'b1, 1'b1, 1'b1, 1'b0);
    chk_bit(ref_recognised_o, 1'b0);
    chk_bit(ref_lost_o, 1'b0);
    set_ref(1'b1, 1'b0, 1'b0, 1'b0);
    chk_bit(ref_lost_o, 1'b0);
    set_ref(1'b0, 1'b0, 1'b0, 1'b0);
    chk_bit(ref_lost_o, 1'b1);
    $display("test hd admit done");
  endtask
  task automatic t_clear;
    set_ref(1'b1, 1'b1, 1'b1, 1'b1);
    bus(1'b1, 10'h214, 32'h4);
    bus(1'b1, 10'h210, 32'hf);
    p0 = pulses;
    bus(1'b1, 10'h20c, 32'h8000);
    repeat (3) @(posedge clk_sys_i);
    chk_word(32'(pulses - p0), 32'h1);
    rdchk(10'h20c, 32'h8000);
    chk_bit(irq_o, 1'b1);
    bus(1'b1, 10'h20c, 32'h8000);
    bus(1'b1, 10'h20c, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    chk_word(32'(pulses - p0), 32'h2);
    bus(1'b1, 10'h214, 32'h0);
    @(negedge clk_sys_i);
    chk_bit(irq_o, 1'b0);
    bus(1'b1, 10'h214, 32'h4);
    @(negedge clk_sys_i);
    chk_bit(irq_o, 1'b1);
    bus(1'b1, 10'h210, 32'h4);
    @(negedge clk_sys_i);
    chk_bit(irq_o, 1'b0);
    $display("test counter clear done");
  endtask
  task automatic t_pin_reset;
    @(posedge clk_sys_i);
    reset_pin_n_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    reset_pin_n_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    rdchk(10'h208, 32'h0);
    rdchk(10'h214, 32'h0);
    $display("test reset pin done");
  endtask
  task automatic t_scan;
    @(negedge clk_sys_i);
    chk_word({28'h0, host_pin_oe_o}, 32'h2);
    chk_bit(tap_enable_o, 1'b0);
    chk_word({28'h0, host_pin_o}, 32'ha);
    chk_bit(host_in_o[1], 1'b1);
    @(posedge clk_sys_i);
    test_select_i <= 1'b1;
    n = 0;
    while (tap_enable_o !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    guard(n);
    chk_word({28'h0, host_pin_oe_o}, 32'h4);
    chk_word({28'h0, host_in_o}, 32'h0);
    chk_bit(test_clock_pin_o, host_pin_i[0]);
    chk_bit(tap_tdi_o, host_pin_i[1]);
    chk_bit(tap_tms_o, host_pin_i[3]);
    chk_bit(host_pin_o[2], tap_tdo_i);
    chk_bit(tap_trst_n_o, 1'b1);
    @(posedge clk_sys_i);
    reset_pin_n_i <= 1'b0;
    n = 0;
    while (tap_trst_n_o !== 1'b0 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    guard(n);
    @(posedge clk_sys_i);
    reset_pin_n_i <= 1'b1;
    test_select_i <= 1'b0;
    n = 0;
    while (tap_enable_o !== 1'b0 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    guard(n);
    chk_bit(test_clock_pin_o, 1'b0);
    $display("test scan port done");
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_hd();
    t_clear();
    t_pin_reset();
    t_scan();
    results();
  end
endmodule
`default_nettype wire
